// ==== design/ext_irq_ctrl.sv ====
// Extended interrupt enable and priority registers with two-level request selection.
// Assumes a byte-wide special-function register port and interrupt flags on clk.
`include "ext_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_irq_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic [7:0] enable_first,
    input wire logic lin_irq_flag,
    input wire logic timer3_irq_flag,
    input wire logic comparator1_irq_flag,
    input wire logic comparator0_irq_flag,
    input wire logic counter_array0_irq_flag,
    input wire logic adc_done_irq_flag,
    input wire logic adc_window_irq_flag,
    input wire logic smbus_irq_flag,
    input wire logic timer5_low_overflow_flag,
    input wire logic timer5_high_overflow_flag,
    input wire logic timer4_low_overflow_flag,
    input wire logic timer4_high_overflow_flag,
    input wire logic comparator2_rise_flag,
    input wire logic comparator2_fall_flag,
    input wire logic counter_array1_irq_flag,
    input wire logic uart_second_irq_flag,
    input wire logic port_match_irq_flag,
    input wire logic can_irq_flag,
    input wire logic regulator_dropout_irq_flag,
    output logic [7:0] extended_irq_enable_second,
    output logic [7:0] extended_irq_priority_first,
    output logic [7:0] extended_irq_priority_second,
    output logic [15:0] irq_pending,
    output logic irq_high_req,
    output logic irq_low_req,
    output logic [3:0] irq_high_source,
    output logic [3:0] irq_low_source
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and decode.

    ext_irq_pkg::sfr_byte_t enable_second_reg;
    ext_irq_pkg::sfr_byte_t priority_first_reg;
    ext_irq_pkg::sfr_byte_t priority_second_reg;
    ext_irq_pkg::sfr_byte_t rdata_reg;
    ext_irq_pkg::sfr_byte_t rdata_next;
    ext_irq_pkg::reg_sel_t reg_sel;
    logic [15:0] pending_reg;
    logic high_req_reg;
    logic low_req_reg;
    ext_irq_pkg::irq_source_t high_source_reg;
    ext_irq_pkg::irq_source_t low_source_reg;

    wire logic hit_enable_second;
    wire logic hit_priority_first;
    wire logic hit_priority_second;
    wire logic wr_enable_second;
    wire logic wr_priority_first;
    wire logic wr_priority_second;

    // Addresses decode without any page qualifier. [R22]
    assign hit_enable_second = (sfr_addr == `EIRQ_ENABLE_SECOND_ADDR);
    assign hit_priority_first = (sfr_addr == `EIRQ_PRIORITY_FIRST_ADDR);
    assign hit_priority_second = (sfr_addr == `EIRQ_PRIORITY_SECOND_ADDR);
    assign sfr_hit = hit_enable_second | hit_priority_first | hit_priority_second;
    assign reg_sel = hit_enable_second ? ext_irq_pkg::SEL_ENABLE_SECOND :
                     hit_priority_first ? ext_irq_pkg::SEL_PRIORITY_FIRST :
                     hit_priority_second ? ext_irq_pkg::SEL_PRIORITY_SECOND :
                     ext_irq_pkg::SEL_NONE;
    assign wr_enable_second = sfr_wr && hit_enable_second;
    assign wr_priority_first = sfr_wr && hit_priority_first;
    assign wr_priority_second = sfr_wr && hit_priority_second;

    // Read mux; unmapped addresses read as zero.
    always_comb
    begin
        case (reg_sel)
            ext_irq_pkg::SEL_ENABLE_SECOND: rdata_next = enable_second_reg;
            ext_irq_pkg::SEL_PRIORITY_FIRST: rdata_next = priority_first_reg;
            ext_irq_pkg::SEL_PRIORITY_SECOND: rdata_next = priority_second_reg;
            default: rdata_next = `EIRQ_UNMAPPED_READ;
        endcase
    end

    // Each register clears on reset; enable and priority registers load on a write to their address, read data on any read. [R22]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enable_second_reg <= `EIRQ_RESET_VALUE;
        else if (wr_enable_second)
            enable_second_reg <= sfr_wdata;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            priority_first_reg <= `EIRQ_RESET_VALUE;
        else if (wr_priority_first)
            priority_first_reg <= sfr_wdata;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            priority_second_reg <= `EIRQ_RESET_VALUE;
        else if (wr_priority_second)
            priority_second_reg <= sfr_wdata;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= `EIRQ_RESET_VALUE;
        else if (sfr_rd)
            rdata_reg <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field views of the enable and priority registers.

    wire logic timer5_irq_enable;
    wire logic timer4_irq_enable;
    wire logic comparator2_irq_enable;
    wire logic counter_array1_irq_enable;
    wire logic uart_second_irq_enable;
    wire logic port_match_irq_enable;
    wire logic can_irq_enable;
    wire logic regulator_dropout_irq_enable;

    assign timer5_irq_enable = enable_second_reg[`SRC_TIMER5];
    assign timer4_irq_enable = enable_second_reg[`SRC_TIMER4];
    assign comparator2_irq_enable = enable_second_reg[`SRC_COMPARATOR2];
    assign counter_array1_irq_enable = enable_second_reg[`SRC_COUNTER_ARRAY1];
    assign uart_second_irq_enable = enable_second_reg[`SRC_UART_SECOND];
    assign port_match_irq_enable = enable_second_reg[`SRC_PORT_MATCH];
    assign can_irq_enable = enable_second_reg[`SRC_CAN];
    assign regulator_dropout_irq_enable = enable_second_reg[`SRC_REGULATOR_DROPOUT];

    logic [7:0] prio_first;
    logic [7:0] prio_second;

    assign prio_first[`SRC_LIN] = priority_first_reg[`SRC_LIN]; // [R1]
    assign prio_first[`SRC_TIMER3] = priority_first_reg[`SRC_TIMER3]; // [R2]
    assign prio_first[`SRC_COMPARATOR1] = priority_first_reg[`SRC_COMPARATOR1]; // [R3]
    assign prio_first[`SRC_COMPARATOR0] = priority_first_reg[`SRC_COMPARATOR0]; // [R3]
    assign prio_first[`SRC_COUNTER_ARRAY0] = priority_first_reg[`SRC_COUNTER_ARRAY0]; // [R4]
    assign prio_first[`SRC_ADC_DONE] = priority_first_reg[`SRC_ADC_DONE]; // [R5]
    assign prio_first[`SRC_ADC_WINDOW] = priority_first_reg[`SRC_ADC_WINDOW]; // [R6]
    assign prio_first[`SRC_SMBUS] = priority_first_reg[`SRC_SMBUS]; // [R7]

    assign prio_second[`SRC_TIMER5] = priority_second_reg[`SRC_TIMER5]; // [R15]
    assign prio_second[`SRC_TIMER4] = priority_second_reg[`SRC_TIMER4]; // [R15]
    assign prio_second[`SRC_COMPARATOR2] = priority_second_reg[`SRC_COMPARATOR2]; // [R16]
    assign prio_second[`SRC_COUNTER_ARRAY1] = priority_second_reg[`SRC_COUNTER_ARRAY1]; // [R17]
    assign prio_second[`SRC_UART_SECOND] = priority_second_reg[`SRC_UART_SECOND]; // [R18]
    assign prio_second[`SRC_PORT_MATCH] = priority_second_reg[`SRC_PORT_MATCH]; // [R19]
    assign prio_second[`SRC_CAN] = priority_second_reg[`SRC_CAN]; // [R20]
    assign prio_second[`SRC_REGULATOR_DROPOUT] =
        priority_second_reg[`SRC_REGULATOR_DROPOUT]; // [R21]

    ////////////////////////////////////////////////////////////////////////////////
    // Request gating: a source passes only with its flag and enable both set.

    logic [7:0] req_first;
    logic [7:0] req_second;

    assign req_first[`SRC_LIN] = lin_irq_flag && enable_first[`SRC_LIN]; // [R23]
    assign req_first[`SRC_TIMER3] = timer3_irq_flag && enable_first[`SRC_TIMER3]; // [R23]
    assign req_first[`SRC_COMPARATOR1] =
        comparator1_irq_flag && enable_first[`SRC_COMPARATOR1]; // [R23]
    assign req_first[`SRC_COMPARATOR0] =
        comparator0_irq_flag && enable_first[`SRC_COMPARATOR0]; // [R23]
    assign req_first[`SRC_COUNTER_ARRAY0] =
        counter_array0_irq_flag && enable_first[`SRC_COUNTER_ARRAY0]; // [R23]
    assign req_first[`SRC_ADC_DONE] = adc_done_irq_flag && enable_first[`SRC_ADC_DONE]; // [R23]
    assign req_first[`SRC_ADC_WINDOW] =
        adc_window_irq_flag && enable_first[`SRC_ADC_WINDOW]; // [R23]
    assign req_first[`SRC_SMBUS] = smbus_irq_flag && enable_first[`SRC_SMBUS]; // [R23]

    assign req_second[`SRC_TIMER5] = timer5_irq_enable &&
        (timer5_low_overflow_flag || timer5_high_overflow_flag); // [R8]
    assign req_second[`SRC_TIMER4] = timer4_irq_enable &&
        (timer4_low_overflow_flag || timer4_high_overflow_flag); // [R8]
    assign req_second[`SRC_COMPARATOR2] = comparator2_irq_enable &&
        (comparator2_rise_flag || comparator2_fall_flag); // [R9]
    assign req_second[`SRC_COUNTER_ARRAY1] =
        counter_array1_irq_enable && counter_array1_irq_flag; // [R10]
    assign req_second[`SRC_UART_SECOND] = uart_second_irq_enable && uart_second_irq_flag; // [R11]
    assign req_second[`SRC_PORT_MATCH] = port_match_irq_enable && port_match_irq_flag; // [R12]
    assign req_second[`SRC_CAN] = can_irq_enable && can_irq_flag; // [R13]
    assign req_second[`SRC_REGULATOR_DROPOUT] =
        regulator_dropout_irq_enable && regulator_dropout_irq_flag; // [R14]

    ////////////////////////////////////////////////////////////////////////////////
    // Priority selection and registered request outputs.

    irq_sel_if #(.N(16), .ID_W(4)) sel_bus ();

    assign sel_bus.req = {req_second, req_first};
    assign sel_bus.prio = {prio_second, prio_first};

    irq_level_select #(.N(16), .ID_W(4)) u_select (
        .sel(sel_bus.sel)
    );

    // The high level is presented whenever any high request exists. [R23]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pending_reg <= '0;
            high_req_reg <= 1'b0;
            low_req_reg <= 1'b0;
            high_source_reg <= '0;
            low_source_reg <= '0;
        end
        else
        begin
            pending_reg <= sel_bus.req;
            high_req_reg <= sel_bus.hi_any;
            low_req_reg <= sel_bus.lo_any && !sel_bus.hi_any;
            high_source_reg <= sel_bus.hi_id;
            low_source_reg <= sel_bus.lo_id;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign extended_irq_enable_second = enable_second_reg;
    assign extended_irq_priority_first = priority_first_reg;
    assign extended_irq_priority_second = priority_second_reg;
    assign irq_pending = pending_reg;
    assign irq_high_req = high_req_reg;
    assign irq_low_req = low_req_reg;
    assign irq_high_source = high_source_reg;
    assign irq_low_source = low_source_reg;

    ext_irq_pkg::sfr_byte_t pending_first;
    ext_irq_pkg::sfr_byte_t pending_second;

    assign {pending_second, pending_first} = pending_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_enable_second_write: // [R22]
        assert property (wr_enable_second |=> enable_second_reg == $past(sfr_wdata))
        else $error("enable register did not take the written byte");

    a_priority_first_write: // [R22]
        assert property (wr_priority_first |=> priority_first_reg == $past(sfr_wdata))
        else $error("first priority register did not take the written byte");

    a_priority_second_write: // [R22]
        assert property (wr_priority_second |=> priority_second_reg == $past(sfr_wdata))
        else $error("second priority register did not take the written byte");

    a_registers_hold: // [R22]
        assert property (!sfr_wr |=> $stable(enable_second_reg) && $stable(priority_first_reg)
                         && $stable(priority_second_reg))
        else $error("register changed without a write");

    a_priority_read_back: // [R22]
        assert property (sfr_rd && hit_priority_second && !sfr_wr
                         |=> sfr_rdata == priority_second_reg)
        else $error("read of second priority register returned the wrong byte");

    a_timer5_masked: // [R8]
        assert property (!timer5_irq_enable |=> !irq_pending[8 + `SRC_TIMER5])
        else $error("timer 5 request passed while masked");

    a_timer4_masked: // [R8]
        assert property (!timer4_irq_enable |=> !pending_second[`SRC_TIMER4])
        else $error("timer 4 request passed while masked");

    a_comparator2_masked: // [R9]
        assert property (!comparator2_irq_enable |=> !pending_second[`SRC_COMPARATOR2])
        else $error("comparator 2 request passed while masked");

    a_counter_array1_masked: // [R10]
        assert property (!counter_array1_irq_enable |=> !pending_second[`SRC_COUNTER_ARRAY1])
        else $error("counter array 1 request passed while masked");

    a_uart_second_masked: // [R11]
        assert property (!uart_second_irq_enable |=> !pending_second[`SRC_UART_SECOND])
        else $error("second UART request passed while masked");

    a_port_match_masked: // [R12]
        assert property (!port_match_irq_enable |=> !pending_second[`SRC_PORT_MATCH])
        else $error("port match request passed while masked");

    a_can_masked: // [R13]
        assert property (!can_irq_enable |=> !pending_second[`SRC_CAN])
        else $error("CAN request passed while masked");

    a_regulator_masked: // [R14]
        assert property (!regulator_dropout_irq_enable
                         |=> !pending_second[`SRC_REGULATOR_DROPOUT])
        else $error("regulator dropout request passed while masked");

    a_comparator2_either: // [R9]
        assert property (comparator2_irq_enable && (comparator2_rise_flag ^ comparator2_fall_flag)
                         |=> irq_pending[8 + `SRC_COMPARATOR2])
        else $error("comparator 2 edge flag did not raise a request");

    a_lin_high_level: // [R1]
        assert property (lin_irq_flag && enable_first[`SRC_LIN] && priority_first_reg[`SRC_LIN]
                         |=> irq_high_req)
        else $error("high priority LIN request not presented");

    a_high_before_low: // [R23]
        assert property ((sel_bus.req & sel_bus.prio) != '0 |=> irq_high_req && !irq_low_req)
        else $error("low request presented while a high one was pending");

    a_low_only: // [R23]
        assert property (sel_bus.req != '0 && (sel_bus.req & sel_bus.prio) == '0
                         |=> irq_low_req && !irq_high_req)
        else $error("low request not presented");

    a_idle_quiet: // [R23]
        assert property (sel_bus.req == '0 |=> !irq_high_req && !irq_low_req)
        else $error("request presented with nothing pending");

    a_high_source_pending: // [R23]
        assert property (irq_high_req |-> irq_pending[irq_high_source])
        else $error("high source id points at a source that is not pending");

    a_low_source_pending: // [R23]
        assert property (irq_low_req |-> irq_pending[irq_low_source])
        else $error("low source id points at a source that is not pending");

    a_unmapped_read: // [R22]
        assert property (sfr_rd && !sfr_hit |=> sfr_rdata == `EIRQ_UNMAPPED_READ)
        else $error("unmapped read returned a nonzero byte");

    a_read_data_hold: // [R22]
        assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

endmodule
`default_nettype wire

// ==== design/ext_irq_map.svh ====
// Addresses, field positions and reset values of the extended interrupt enable and priority block.
// Assumes inclusion by bare name from the design files; definitions only.
//
// Notes on behaviour
// R1 - Priority-first bit 7 puts the LIN interrupt at low (0) or high (1) priority.
// R2 - Priority-first bit 6 puts the timer 3 interrupt at low or high priority.
// R3 - Priority-first bits 5 and 4 set comparator 1 and comparator 0 priority.
// R4 - Priority-first bit 3 sets priority for all counter array 0 interrupts.
// R5 - Priority-first bit 2 sets priority of the ADC conversion-complete interrupt.
// R6 - Priority-first bit 1 sets priority of the ADC window interrupt.
// R7 - Priority-first bit 0 sets priority of the SMBus interrupt.
// R8 - Enable-second bits 7 and 6 pass timer 5 and timer 4 overflow requests.
// R9 - Enable-second bit 5 lets comparator 2 rise or fall flag request.
// R10 - Enable-second bit 4 masks or enables all counter array 1 interrupts.
// R11 - Enable-second bit 3 enables the second UART interrupt.
// R12 - Enable-second bit 2 masks or enables port match interrupts.
// R13 - Enable-second bit 1 masks or enables all CAN controller interrupts.
// R14 - Enable-second bit 0 enables the regulator dropout interrupt.
// R15 - Priority-second bits 7 and 6 set timer 5 and timer 4 priority.
// R16 - Priority-second bit 5 sets the comparator 2 interrupt priority.
// R17 - Priority-second bit 4 sets counter array 1 interrupt priority.
// R18 - Priority-second bit 3 sets second UART interrupt priority.
// R19 - Priority-second bit 2 sets port match interrupt priority.
// R20 - Priority-second bit 1 sets CAN controller interrupt priority.
// R21 - Priority-second bit 0 sets regulator dropout interrupt priority.
// R22 - All three registers read and write on every page and clear on reset.
// R23 - A request passes only with flag and enable set; high priority goes first.

`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

`define EIRQ_ENABLE_SECOND_ADDR 8'he7
`define EIRQ_PRIORITY_FIRST_ADDR 8'hf6
`define EIRQ_PRIORITY_SECOND_ADDR 8'hf7
`define EIRQ_RESET_VALUE 8'h00
`define EIRQ_UNMAPPED_READ 8'h00

`define SRC_LIN 7
`define SRC_TIMER3 6
`define SRC_COMPARATOR1 5
`define SRC_COMPARATOR0 4
`define SRC_COUNTER_ARRAY0 3
`define SRC_ADC_DONE 2
`define SRC_ADC_WINDOW 1
`define SRC_SMBUS 0

`define SRC_TIMER5 7
`define SRC_TIMER4 6
`define SRC_COMPARATOR2 5
`define SRC_COUNTER_ARRAY1 4
`define SRC_UART_SECOND 3
`define SRC_PORT_MATCH 2
`define SRC_CAN 1
`define SRC_REGULATOR_DROPOUT 0

`endif

// ==== design/ext_irq_pkg.sv ====
// Types shared by the extended interrupt enable and priority block.
// Assumes nothing beyond a SystemVerilog compiler.
package ext_irq_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [3:0] irq_source_t;
    typedef enum logic [2:0]
    {
        SEL_NONE = 3'b000,
        SEL_ENABLE_SECOND = 3'b001,
        SEL_PRIORITY_FIRST = 3'b010,
        SEL_PRIORITY_SECOND = 3'b100
    } reg_sel_t;
endpackage

// ==== design/irq_sel_if.sv ====
// Carrier between the register block and its priority selector.
// Assumes one clock domain; the signals are combinational.
`timescale 1ns/1ps
`default_nettype none
interface irq_sel_if #(parameter int N = 16, parameter int ID_W = 4);
    logic [N-1:0] req;
    logic [N-1:0] prio;
    logic hi_any;
    logic lo_any;
    logic [ID_W-1:0] hi_id;
    logic [ID_W-1:0] lo_id;
    modport src (output req, output prio, input hi_any, input lo_any, input hi_id, input lo_id);
    modport sel (input req, input prio, output hi_any, output lo_any, output hi_id, output lo_id);
endinterface
`default_nettype wire

// ==== design/irq_level_select.sv ====
// Two-level priority selector: picks the lowest-numbered request at each level.
// Assumes request and priority vectors from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module irq_level_select #(
    parameter int N = 16,
    parameter int ID_W = 4
)(
    irq_sel_if.sel sel
);
    generate
        if (N < 2 || N > (1 << ID_W))
        begin : g_bad_width
            $error("irq_level_select: N does not fit the source id width");
        end
    endgenerate

    // Scans from the top so that the lowest-numbered request wins each level.
    always_comb
    begin
        sel.hi_any = 1'b0;
        sel.lo_any = 1'b0;
        sel.hi_id = '0;
        sel.lo_id = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (sel.req[i] && sel.prio[i])
            begin
                sel.hi_any = 1'b1;
                sel.hi_id = ID_W'(i);
            end
            if (sel.req[i] && !sel.prio[i])
            begin
                sel.lo_any = 1'b1;
                sel.lo_id = ID_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/irq_cpu_model.sv ====
// Behavioural model of the CPU vectoring logic fed by the extended interrupt block.
// Assumes the request and source outputs of the block on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module irq_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic high_req,
    input wire logic low_req,
    input wire logic [3:0] high_source,
    input wire logic [3:0] low_source,
    output logic vec_valid,
    output logic vec_high,
    output logic [3:0] vec_id
);
    ////////////////////////////////////////////////////////////////////////////
    // The vector taken is the high level source if one exists, else the low one.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vec_valid <= 1'b0;
            vec_high <= 1'b0;
            vec_id <= 4'h0;
        end
        else
        begin
            vec_valid <= high_req | low_req;
            vec_high <= high_req;
            vec_id <= high_req ? high_source : (low_req ? low_source : 4'h0);
        end
    end
endmodule
`default_nettype wire

// ==== dv/extended_interrupt_enable_priority_tb_top.sv ====
// Self-checking bench for the extended interrupt enable and priority block.
// Assumes the design files and the vectoring model are compiled first.
`include "ext_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module extended_interrupt_enable_priority_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] enable_first = 8'h00;
    logic [15:0] flg = 16'h0000;
    logic alt = 1'b0;
    logic [7:0] sfr_rdata, en2, pr1, pr2;
    logic sfr_hit, hi_req, lo_req, v_valid, v_high;
    logic [15:0] pend;
    logic [3:0] hi_src, lo_src, v_id;
    int fails = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    ext_irq_ctrl dut (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .enable_first(enable_first), .smbus_irq_flag(flg[0]), .adc_window_irq_flag(flg[1]),
        .adc_done_irq_flag(flg[2]), .counter_array0_irq_flag(flg[3]),
        .comparator0_irq_flag(flg[4]), .comparator1_irq_flag(flg[5]),
        .timer3_irq_flag(flg[6]), .lin_irq_flag(flg[7]),
        .regulator_dropout_irq_flag(flg[8]), .can_irq_flag(flg[9]),
        .port_match_irq_flag(flg[10]), .uart_second_irq_flag(flg[11]),
        .counter_array1_irq_flag(flg[12]), .comparator2_rise_flag(flg[13] & ~alt),
        .comparator2_fall_flag(flg[13] & alt), .timer4_low_overflow_flag(flg[14] & ~alt),
        .timer4_high_overflow_flag(flg[14] & alt), .timer5_low_overflow_flag(flg[15] & ~alt),
        .timer5_high_overflow_flag(flg[15] & alt), .extended_irq_enable_second(en2),
        .extended_irq_priority_first(pr1), .extended_irq_priority_second(pr2),
        .irq_pending(pend), .irq_high_req(hi_req), .irq_low_req(lo_req),
        .irq_high_source(hi_src), .irq_low_source(lo_src)
    );
    irq_cpu_model cpu (
        .clk(clk), .rst(rst), .high_req(hi_req), .low_req(lo_req), .high_source(hi_src),
        .low_source(lo_src), .vec_valid(v_valid), .vec_high(v_high), .vec_id(v_id)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Shared comparison, bus cycles and closing.
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask
    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs;
        logic [7:0] a [3];
        logic [7:0] d;
        a = '{`EIRQ_ENABLE_SECOND_ADDR, `EIRQ_PRIORITY_FIRST_ADDR, `EIRQ_PRIORITY_SECOND_ADDR};
        for (int i = 0; i < 3; i++)
        begin
            rd(a[i], d);
            chk("reset value", {8'h00, d}, 16'h0000);
            chk("address hit", {15'h0000, sfr_hit}, 16'h0001);
        end
        for (int i = 0; i < 3; i++)
            wr(a[i], 8'h5a ^ 8'(i * 8'h11));
        @(negedge clk);
        chk("register ports", {en2, pr1}, 16'h5a4b);
        chk("register port 2", {8'h00, pr2}, 16'h0078);
        for (int i = 0; i < 3; i++)
        begin
            rd(a[i], d);
            chk("read back", {8'h00, d}, {8'h00, 8'h5a ^ 8'(i * 8'h11)});
        end
        rd(8'he6, d);
        chk("unmapped read", {7'h00, sfr_hit, d}, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        settle();
        chk("second reset", {en2, pr1}, 16'h0000);
        chk("second reset 2", {8'h00, pr2}, 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        $display("test registers done");
    endtask
    task automatic t_enable;
        logic [7:0] b;
        logic [15:0] one;
        for (int id = 0; id < 16; id++)
            for (int s = 0; s < 2; s++)
            begin
                b = 8'h01 << id[2:0];
                one = 16'h0001 << id;
                @(posedge clk);
                flg <= one;
                alt <= s[0];
                enable_first <= (id < 8) ? ~b : 8'hff;
                wr(`EIRQ_ENABLE_SECOND_ADDR, (id < 8) ? 8'hff : ~b);
                settle();
                if (id < 8)
                    chk("masked", pend, 16'h0000);
                else
                    chk("masked", pend, 16'h0000);
                @(posedge clk);
                enable_first <= (id < 8) ? b : 8'h00;
                wr(`EIRQ_ENABLE_SECOND_ADDR, (id < 8) ? 8'h00 : b);
                settle();
                if (id < 8)
                    chk("enabled", pend, one);
                else
                    chk("enabled", pend, one);
                chk("low source", {11'h000, lo_req, lo_src}, {11'h000, 1'b1, 4'(id)});
            end
        $display("test enable done");
    endtask
    task automatic t_priority;
        logic [7:0] b;
        logic [7:0] a;
        logic [15:0] s;
        logic [15:0] e;
        @(posedge clk);
        enable_first <= 8'hff;
        wr(`EIRQ_ENABLE_SECOND_ADDR, 8'hff);
        for (int id = 0; id < 16; id++)
        begin
            b = 8'h01 << id[2:0];
            a = (id < 8) ? `EIRQ_PRIORITY_FIRST_ADDR : `EIRQ_PRIORITY_SECOND_ADDR;
            flg <= 16'h0001 << id;
            wr(a, b);
            settle();
            s = {10'h000, hi_req, lo_req, hi_src};
            e = {10'h000, 2'b10, 4'(id)};
            if (id < 8)
                chk("high level", s, e);
            else
                chk("high level", s, e);
            settle();
            chk("vector high", {v_valid, v_high, v_id}, {2'b11, 4'(id)});
            wr(a, ~b);
            settle();
            s = {10'h000, hi_req, lo_req, lo_src};
            e = {10'h000, 2'b01, 4'(id)};
            if (id < 8)
                chk("low level", s, e);
            else
                chk("low level", s, e);
            wr(a, 8'h00);
        end
        $display("test priority done");
    endtask
    task automatic t_order;
        @(posedge clk);
        flg <= 16'h0b04;
        wr(`EIRQ_PRIORITY_SECOND_ADDR, 8'h0a);
        settle();
        chk("order", {hi_req, lo_req, hi_src, lo_src}, {2'b10, 4'h9, 4'h2});
        settle();
        chk("vector order", {v_valid, v_high, v_id}, {2'b11, 4'h9});
        @(posedge clk);
        flg <= 16'h0000;
        settle();
        chk("idle", {pend[13:0], hi_req, lo_req}, 16'h0000);
        $display("test order done");
    endtask
    initial
    begin
        #100000;
        fails++;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_enable();
        t_priority();
        t_order();
        final_report();
    end
endmodule
`default_nettype wire
